// file: hdl/hbc_pkg.sv
// package: register map, field layout and constants for half-bridge control
package hbc_pkg;
  // apb register byte offsets
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  localparam logic [7:0] ADDR_DUTY01 = 8'h0C;
  localparam logic [7:0] ADDR_DUTY23 = 8'h10;
  localparam logic [7:0] ADDR_OC = 8'h14;
  localparam logic [7:0] ADDR_STEP = 8'h18;
  localparam logic [7:0] ADDR_AUX3 = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  // enable register fields
  localparam int EN_B12_BIT = 0;
  localparam int EN_B34_BIT = 1;
  // config register fields
  localparam int CFG_PAR12_BIT = 0;
  localparam int CFG_PAR34_BIT = 1;
  localparam int CFG_STEPPER_BIT = 2;
  localparam int CFG_SRC_LSB = 4;
  localparam int CFG_OFFT_LSB = 8;
  // stepper register fields
  localparam int STP_DECAY_BIT = 0;
  localparam int STP_DIR_BIT = 1;
  localparam int STP_EXT_CLK_BIT = 2;
  localparam int STP_HALF_BIT = 3;
  localparam int STP_OFFT_LSB = 4;
  localparam int STP_BLANK_LSB = 8;
  localparam int STP_VREF_LSB = 12;
  // oc threshold fields
  localparam int OC_THR_W = 4;
  localparam logic [3:0] OC_FIXED_THR = 4'hF;
  // widths and counts
  localparam int NUM_HB = 8;
  localparam int DUTY_W = 8;
  localparam logic [7:0] PWM_PERIOD_M1 = 8'hFE;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  // drive modes, 3 bits per half-bridge
  typedef enum logic [2:0] {
    HB_LOW = 3'h0,
    HB_HIGH = 3'h1,
    HB_FLOAT = 3'h2,
    HB_PWM_HIGH_LOW = 3'h3,
    HB_PWM_FLOAT_LOW = 3'h4,
    HB_PWM_HIGH_FLOAT = 3'h5
  } hbc_mode_t;
  // stepper sequencer states, gray along the step path
  typedef enum logic [1:0] {
    ST_A = 2'b00,
    ST_B = 2'b01,
    ST_C = 2'b11,
    ST_D = 2'b10
  } hbc_step_t;
endpackage

// file: hdl/hbc_aux_pwm.sv
// file: third auxiliary pwm generator with high, low time and period
`timescale 1ns/1ps
module hbc_aux_pwm
  import hbc_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // settings
  input wire logic [7:0] high_time_in,
  input wire logic [7:0] low_time_in,
  input wire logic [7:0] period_in,
  // outputs
  output logic pwm_out,
  output logic period_tick_out
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;

  // high phase for high_time cycles, low for the rest of the count, wrap at period
  always_comb begin
    next_cnt = cnt + 8'h01;
    if (cnt >= period_in) begin
      next_cnt = 8'h00;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      cnt <= 8'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      pwm_out <= 1'b0;
      period_tick_out <= 1'b0;
    end else begin
      pwm_out <= (cnt < high_time_in) &&
                 ((high_time_in | low_time_in) != 8'h00);
      period_tick_out <= (cnt >= period_in) && (period_in != 8'h00);
    end
  end
endmodule

// file: hdl/hbc_top.sv
// file: half-bridge output control with apb registers and stepper sequencer
`timescale 1ns/1ps
// Operation
// - each half-bridge can be held low, held high or floated
// - pwm modes alternate high/low, float/low or high/float
// - all outputs float from reset until software enables bridges
// - parallel 1 and 2: bridge one logic drives both bridges
// - parallel 3 and 4: bridge three logic drives both bridges
// - bridges 1,2 have pwm source, duty, oc threshold, oc off-time
// - bridges 3,4 use fixed oc threshold; others programmable
// - duty resets to zero; no pwm activity on internal source until duty programmed
// - stepper mode hands bridges 3 and 4 to stepper controller
// - stepper has decay, off, blank, vref, direction, mode, clock
// - external step clock from gpio 12, one step per rising edge
// - aux pwm three has high, low, period; period sets step rate
module hbc_top
  import hbc_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // external pwm inputs per bridge and step clock pin
  input wire logic [3:0] EXT_PWM_IN,
  input wire logic GPIO12_STEP_CLK_IN,
  // half-bridge drives: high switch on, low switch on
  output logic [NUM_HB-1:0] HS_ON_OUT,
  output logic [NUM_HB-1:0] LS_ON_OUT,
  // settings seen by analog protection and stepper current loop
  output logic [OC_THR_W-1:0] OC_THR_B1_OUT,
  output logic [OC_THR_W-1:0] OC_THR_B2_OUT,
  output logic [OC_THR_W-1:0] OC_THR_B34_OUT,
  output logic [15:0] OC_OFFTIME_OUT,
  output logic [15:0] STEP_CURRENT_CFG_OUT,
  // aux pwm three, for routing to a gpio
  output logic AUX3_PWM_OUT
);
  logic [1:0] enable;
  logic [15:0] config_r;
  logic [23:0] mode;
  logic [15:0] duty01;
  logic [15:0] duty23;
  logic [7:0] oc_thr;
  logic [15:0] step_cfg;
  logic [23:0] aux3_cfg;
  logic [1:0] step_pos;
  logic gpio_d;
  logic aux_pwm;
  logic aux_tick;
  logic [7:0] pwm_cnt;
  logic [3:0] int_pwm;
  logic [3:0] bridge_pwm;
  logic step_evt;
  logic wr;
  logic rd;
  logic addr_ok;
  logic [31:0] next_rdata;
  hbc_step_t step_state;
  hbc_step_t next_step;
  logic [NUM_HB-1:0] next_hs;
  logic [NUM_HB-1:0] next_ls;

  assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign rd = PSEL_IN && PENABLE_IN && !PWRITE_IN;

  // apb register writes; zero-wait answer
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      enable <= 2'b00;
      config_r <= RESET_ZERO[15:0];
      mode <= {8{HB_FLOAT}};
      duty01 <= RESET_ZERO[15:0];
      duty23 <= RESET_ZERO[15:0];
      oc_thr <= RESET_ZERO[7:0];
      step_cfg <= RESET_ZERO[15:0];
      aux3_cfg <= RESET_ZERO[23:0];
    end else if (wr) begin
      case (PADDR_IN)
        ADDR_ENABLE: begin
          enable <= PWDATA_IN[1:0];
        end
        ADDR_CONFIG: begin
          config_r <= PWDATA_IN[15:0];
        end
        ADDR_MODE: begin
          mode <= PWDATA_IN[23:0];
        end
        ADDR_DUTY01: begin
          duty01 <= PWDATA_IN[15:0];
        end
        ADDR_DUTY23: begin
          duty23 <= PWDATA_IN[15:0];
        end
        ADDR_OC: begin
          oc_thr <= PWDATA_IN[7:0];
        end
        ADDR_STEP: begin
          step_cfg <= PWDATA_IN[15:0];
        end
        ADDR_AUX3: begin
          aux3_cfg <= PWDATA_IN[23:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    addr_ok = 1'b1;
    next_rdata = RESET_ZERO;
    case (PADDR_IN)
      ADDR_ENABLE: next_rdata = {30'h0, enable};
      ADDR_CONFIG: next_rdata = {16'h0, config_r};
      ADDR_MODE: next_rdata = {8'h0, mode};
      ADDR_DUTY01: next_rdata = {16'h0, duty01};
      ADDR_DUTY23: next_rdata = {16'h0, duty23};
      ADDR_OC: next_rdata = {24'h0, oc_thr};
      ADDR_STEP: next_rdata = {16'h0, step_cfg};
      ADDR_AUX3: next_rdata = {8'h0, aux3_cfg};
      ADDR_STATUS: next_rdata = {24'h0, pwm_cnt[7:6], step_pos, int_pwm};
      default: addr_ok = 1'b0;
    endcase
  end

  // read data registered during the setup cycle, ready in access phase
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      PRDATA_OUT <= RESET_ZERO;
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= PSEL_IN && !PENABLE_IN;
      PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && !addr_ok;
      if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
        PRDATA_OUT <= next_rdata;
      end
    end
  end

  // internal pwm carrier, period 255 cycles
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      pwm_cnt <= 8'h00;
    end else if (pwm_cnt >= PWM_PERIOD_M1) begin
      pwm_cnt <= 8'h00;
    end else begin
      pwm_cnt <= pwm_cnt + 8'h01;
    end
  end

  // per-bridge pwm: duty/255 of the period in first state
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_br
      logic [7:0] duty;
      assign duty = (b < 2) ? duty01[8*(b%2) +: 8] : duty23[8*(b%2) +: 8];
      assign int_pwm[b] = pwm_cnt < duty;
      assign bridge_pwm[b] = config_r[CFG_SRC_LSB+b] ?
                             EXT_PWM_IN[b] : int_pwm[b];
    end
  endgenerate

  // aux generator three: high time, low time, period
  hbc_aux_pwm u_aux3 (
    .CLK_IN(CLK_IN),
    .RST_N_IN(RST_N_IN),
    .high_time_in(aux3_cfg[7:0]),
    .low_time_in(aux3_cfg[15:8]),
    .period_in(aux3_cfg[23:16]),
    .pwm_out(aux_pwm),
    .period_tick_out(aux_tick)
  );

  // step event: gpio 12 rising edge or aux period tick
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      gpio_d <= 1'b0;
    end else begin
      gpio_d <= GPIO12_STEP_CLK_IN;
    end
  end
  assign step_evt = step_cfg[STP_EXT_CLK_BIT] ?
                    (GPIO12_STEP_CLK_IN && !gpio_d) : aux_tick;

  always_comb begin
    next_step = step_state;
    if (step_evt) begin
      case (step_state)
        ST_A: next_step = step_cfg[STP_DIR_BIT] ? ST_D : ST_B;
        ST_B: next_step = step_cfg[STP_DIR_BIT] ? ST_A : ST_C;
        ST_C: next_step = step_cfg[STP_DIR_BIT] ? ST_B : ST_D;
        ST_D: next_step = step_cfg[STP_DIR_BIT] ? ST_C : ST_A;
        default: next_step = ST_A;
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      step_state <= ST_A;
    end else if (config_r[CFG_STEPPER_BIT] && enable[EN_B34_BIT]) begin
      step_state <= next_step;
    end
  end
  assign step_pos = step_state;

  // half-bridge drive decode
  function automatic logic [1:0] hb_drive(input logic [2:0] m,
                                          input logic p);
    logic [1:0] d;
    d = 2'b00;
    case (m)
      HB_LOW: d = 2'b01;
      HB_HIGH: d = 2'b10;
      HB_FLOAT: d = 2'b00;
      HB_PWM_HIGH_LOW: d = p ? 2'b10 : 2'b01;
      HB_PWM_FLOAT_LOW: d = p ? 2'b00 : 2'b01;
      HB_PWM_HIGH_FLOAT: d = p ? 2'b10 : 2'b00;
      default: d = 2'b00;
    endcase
    return d;
  endfunction

  // hb index: bridge k has + at 2k and - at 2k+1
  always_comb begin
    logic [1:0] d;
    logic [2:0] m;
    logic p;
    integer src;
    d = 2'b00;
    m = 3'h0;
    p = 1'b0;
    src = 0;
    next_hs = '0;
    next_ls = '0;
    for (int i = 0; i < NUM_HB; i++) begin
      src = i;
      if (config_r[CFG_PAR12_BIT] && (i == 2 || i == 3)) begin
        src = i - 2;
      end
      if (config_r[CFG_PAR34_BIT] && (i == 6 || i == 7)) begin
        src = i - 2;
      end
      m = mode[3*src +: 3];
      p = bridge_pwm[src/2];
      d = hb_drive(m, p);
      if (i >= 4 && config_r[CFG_STEPPER_BIT]) begin
        // full step phase drive, every leg driven high or low, floated only while bridges 3-4 are disabled
        case (i)
          4: d = step_state[1] ? 2'b01 : 2'b10;
          5: d = step_state[1] ? 2'b10 : 2'b01;
          6: d = (step_state[1] ^ step_state[0]) ? 2'b01 : 2'b10;
          default: d = (step_state[1] ^ step_state[0]) ? 2'b10 : 2'b01;
        endcase
      end
      if (!enable[(i < 4) ? EN_B12_BIT : EN_B34_BIT]) begin
        d = 2'b00;
      end
      next_hs[i] = d[1];
      next_ls[i] = d[0];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      HS_ON_OUT <= '0;
      LS_ON_OUT <= '0;
      AUX3_PWM_OUT <= 1'b0;
    end else begin
      HS_ON_OUT <= next_hs;
      LS_ON_OUT <= next_ls;
      AUX3_PWM_OUT <= aux_pwm;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      OC_THR_B1_OUT <= '0;
      OC_THR_B2_OUT <= '0;
      OC_THR_B34_OUT <= OC_FIXED_THR;
      OC_OFFTIME_OUT <= '0;
      STEP_CURRENT_CFG_OUT <= '0;
    end else begin
      OC_THR_B1_OUT <= oc_thr[3:0];
      OC_THR_B2_OUT <= oc_thr[7:4];
      OC_THR_B34_OUT <= OC_FIXED_THR;
      OC_OFFTIME_OUT <= {8'h00, config_r[CFG_OFFT_LSB +: 8]};
      STEP_CURRENT_CFG_OUT <= step_cfg;
    end
  end

  // assertions
  AST_FLOAT_DISABLED: assert property (@(posedge CLK_IN) disable iff
    (!RST_N_IN) !enable[EN_B12_BIT] |=> (HS_ON_OUT[3:0] == 4'h0 &&
    LS_ON_OUT[3:0] == 4'h0))
    else $error("bridges 1-2 drive while disabled");
  AST_NO_SHOOT: assert property (@(posedge CLK_IN) disable iff
    (!RST_N_IN) (HS_ON_OUT & LS_ON_OUT) == '0)
    else $error("both switches on");
  AST_ZERO_DUTY: assert property (@(posedge CLK_IN) disable iff
    (!RST_N_IN) (duty01[7:0] == 8'h00) |-> !int_pwm[0])
    else $error("pwm active with zero duty");
  AST_PAR12: assert property (@(posedge CLK_IN) disable iff
    (!RST_N_IN) config_r[CFG_PAR12_BIT] && $stable(config_r) |=>
    HS_ON_OUT[3:2] == HS_ON_OUT[1:0])
    else $error("parallel 12 mismatch");
  AST_PAR34: assert property (@(posedge CLK_IN) disable iff
    (!RST_N_IN) config_r[CFG_PAR34_BIT] && !config_r[CFG_STEPPER_BIT]
    |=> LS_ON_OUT[7:6] == LS_ON_OUT[5:4])
    else $error("parallel 34 mismatch");
  AST_FIXED_THR: assert property (@(posedge CLK_IN) disable iff
    (!RST_N_IN) OC_THR_B34_OUT == OC_FIXED_THR)
    else $error("bridge 3-4 threshold changed");
  AST_STEP_EXT: assert property (@(posedge CLK_IN) disable iff
    (!RST_N_IN) step_cfg[STP_EXT_CLK_BIT] && !step_evt |=>
    $stable(step_state))
    else $error("step moved without clock");
  AST_STEPPER_OWNS: assert property (@(posedge CLK_IN) disable iff
    (!RST_N_IN) config_r[CFG_STEPPER_BIT] && enable[EN_B34_BIT] &&
    $stable(config_r) && $stable(enable) |=>
    (HS_ON_OUT[7:4] ^ LS_ON_OUT[7:4]) == 4'hF)
    else $error("stepper not driving bridges 3-4");
  AST_DUTY_FRAC: assert property (@(posedge CLK_IN) disable iff
    (!RST_N_IN) (pwm_cnt >= duty01[7:0]) |-> !int_pwm[0])
    else $error("pwm first state past duty");
  AST_AUX_TICK: assert property (@(posedge CLK_IN) disable iff
    (!RST_N_IN) aux_tick |=> !aux_tick)
    else $error("aux period tick too long");

  // zero duty on bridge one, internal source, pwm high/float on its + leg
  sequence s_b1_zero_duty;
    enable[EN_B12_BIT] && !config_r[CFG_SRC_LSB] &&
    (duty01[7:0] == 8'h00) && (mode[2:0] == HB_PWM_HIGH_FLOAT);
  endsequence
  sequence s_b1_pos_float;
    !HS_ON_OUT[0] && !LS_ON_OUT[0];
  endsequence
  AST_ZERO_DUTY_OUT: assert property (@(posedge CLK_IN) disable iff
    (!RST_N_IN) s_b1_zero_duty |=> s_b1_pos_float)
    else $error("bridge one leaves second state with zero duty");

  // a sampled rising edge on the step pin moves the sequencer once
  sequence s_ext_step_edge;
    config_r[CFG_STEPPER_BIT] && enable[EN_B34_BIT] &&
    step_cfg[STP_EXT_CLK_BIT] && GPIO12_STEP_CLK_IN && !gpio_d;
  endsequence
  AST_STEP_ADV: assert property (@(posedge CLK_IN) disable iff
    (!RST_N_IN) s_ext_step_edge |=>
    step_state != $past(step_state))
    else $error("step clock edge did not advance the sequencer");
endmodule

// file: dv/hbc_winding_model.sv
// motor winding model: resolves each half-bridge to low, high, float or both switches on
`timescale 1ns/1ps
module hbc_winding_model
  import hbc_pkg::*;
(
  // switch commands from the bridges
  input wire logic [NUM_HB-1:0] hs_on_in,
  input wire logic [NUM_HB-1:0] ls_on_in,
  // level per half-bridge: 0 low, 1 high, 2 float, 3 both switches on
  output logic [2*NUM_HB-1:0] level_out
);
  // a winding sees float when neither switch conducts
  always_comb begin
    for (int i = 0; i < NUM_HB; i++) begin
      if (hs_on_in[i] && ls_on_in[i]) begin
        level_out[2*i+:2] = 2'h3;
      end else if (hs_on_in[i]) begin
        level_out[2*i+:2] = 2'h1;
      end else if (ls_on_in[i]) begin
        level_out[2*i+:2] = 2'h0;
      end else begin
        level_out[2*i+:2] = 2'h2;
      end
    end
  end
endmodule

// file: dv/hbc_top_tb.sv
// self-checking bench for half-bridge output control
`timescale 1ns/1ps
`define CHK(a, e) begin \
  cmp_count++; \
  if ((a) !== (e)) begin \
    miscompares++; \
    $display("wrong value at %0t: got %0h exp %0h", $time, a, e); \
  end \
end
module hbc_top_tb;
  import hbc_pkg::*;
  logic clk, rst_n, psel, pen, pwr, gp12, e, aux3;
  logic [7:0] paddr, hs, ls, p;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr;
  logic [3:0] ext_pwm, thr1, thr2, thr34;
  logic [15:0] offt, stcfg, lvl;
  logic [1:0] fs [3] = '{2'h1, 2'h2, 2'h1};
  logic [1:0] ss [3] = '{2'h0, 2'h0, 2'h2};
  logic [1:0] gray [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int miscompares = 0, cmp_count = 0, cycles = 0, c, k;
  hbc_top hbc_top_inst (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .EXT_PWM_IN(ext_pwm),
    .GPIO12_STEP_CLK_IN(gp12), .HS_ON_OUT(hs), .LS_ON_OUT(ls),
    .OC_THR_B1_OUT(thr1), .OC_THR_B2_OUT(thr2), .OC_THR_B34_OUT(thr34),
    .OC_OFFTIME_OUT(offt), .STEP_CURRENT_CFG_OUT(stcfg),
    .AUX3_PWM_OUT(aux3));
  hbc_winding_model hbc_winding_model_inst (.hs_on_in(hs), .ls_on_in(ls),
    .level_out(lvl));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, r, e);
  endtask
  function automatic logic [31:0] mw(input int j, input logic [2:0] a,
      input logic [2:0] b, input logic [2:0] f);
    logic [31:0] w;
    w = 32'h0;
    for (int i = 0; i < 8; i++) w[3*i+:3] = i == j ? a : i == j+1 ? b : f;
    return w;
  endfunction
  // cycles in one full pwm period where half-bridge h shows level s
  task automatic win(input int h, input logic [1:0] s);
    c = 0;
    repeat (255) begin
      @(posedge clk);
      if (lvl[2*h+:2] === s) c++;
    end
  endtask
  task automatic pulse();
    gp12 <= 1'b1;
    wt(3);
    gp12 <= 1'b0;
    wt(4);
  endtask
  // cycles until bridges 3 and 4 change their pattern
  task automatic chg();
    p = lvl[15:8];
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (lvl[15:8] === p && c < 100);
  endtask
  initial begin
    {rst_n, psel, pen, pwr, gp12, paddr, pwdata, ext_pwm} = '0;
    wt(3);
    rst_n <= 1'b1;
    wt(1);
    for (int i = 0; i < 8; i++) begin
      rd(8'(4*i));
      `CHK(r, i == 2 ? mw(0, 3'h2, 3'h2, 3'h2) : 32'h0)
    end
    `CHK(hs | ls, 8'h00)
    apb(1'b0, 8'h24, 32'h0, r, e);
    `CHK({e, r}, 33'h1_0000_0000)
    // modes set before enabling must not reach the bridges
    wr(ADDR_MODE, mw(0, 3'h1, 3'h1, 3'h1));
    wt(4);
    `CHK(hs | ls, 8'h00)
    wr(ADDR_ENABLE, 32'h3);
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_MODE, mw(0, 3'(m), 3'(m), 3'(m)));
      wt(4);
      `CHK(lvl, {8{2'(m)}})
    end
    wr(ADDR_DUTY01, 32'h40);
    for (int m = 3; m < 6; m++) begin
      wr(ADDR_MODE, mw(0, 3'(m), 3'(m), 3'(m)));
      wt(4);
      win(0, fs[m-3]);
      `CHK(c, 64)
      win(0, ss[m-3]);
      `CHK(c, 191)
      win(2, ss[m-3]);
      `CHK(c, 255)
    end
    wr(ADDR_DUTY01, 32'h0);
    wr(ADDR_CONFIG, 32'h1);
    wr(ADDR_MODE, mw(0, 3'h1, 3'h0, 3'h2));
    wt(4);
    `CHK(lvl, 16'hAA11)
    wr(ADDR_CONFIG, 32'h2);
    wr(ADDR_MODE, mw(4, 3'h1, 3'h0, 3'h2));
    wt(4);
    `CHK(lvl, 16'h11AA)
    wr(ADDR_OC, 32'hA5);
    wr(ADDR_CONFIG, 32'h3C10);
    wr(ADDR_MODE, mw(0, 3'h3, 3'h3, 3'h2));
    ext_pwm <= 4'h1;
    wt(4);
    `CHK({thr2, thr1}, 8'hA5)
    `CHK(thr34, OC_FIXED_THR)
    `CHK(offt, 16'h003C)
    `CHK(lvl[3:0], 4'h5)
    ext_pwm <= 4'h0;
    wt(4);
    `CHK(lvl[3:0], 4'h0)
    wr(ADDR_CONFIG, 32'h4);
    wr(ADDR_STEP, 32'h9655);
    wt(4);
    `CHK(stcfg, 16'h9655)
    rd(ADDR_STATUS);
    k = 0;
    for (int i = 0; i < 4; i++) if (gray[i] === r[5:4]) k = i;
    for (int i = 1; i < 5; i++) begin
      p = lvl[15:8];
      pulse();
      rd(ADDR_STATUS);
      `CHK(r[5:4], gray[(k+i)%4])
      `CHK(lvl[15:8] !== p, 1'b1)
    end
    wr(ADDR_STEP, 32'h9657);
    pulse();
    rd(ADDR_STATUS);
    `CHK(r[5:4], gray[(k+3)%4])
    wr(ADDR_AUX3, 32'h0009_0302);
    wr(ADDR_STEP, 32'h9651);
    chg();
    chg();
    `CHK(c, 10)
    c = 0;
    repeat (10) begin
      @(posedge clk);
      if (aux3 === 1'b1) c++;
    end
    `CHK(c, 2)
    tally_and_finish();
  end
endmodule
